// ### verilog/ssotp_pkg.sv
`default_nettype none
package ssotp_pkg;
  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned PWM_HZ     = 500;
  localparam int unsigned PWM_CYC    = CLK_HZ / PWM_HZ;
  localparam int unsigned OV_DET_US  = 50;
  localparam int unsigned OV_DET_CYC = CLK_HZ / 1_000_000 * OV_DET_US;
  localparam int unsigned WAIT_MS    = 1;
  localparam int unsigned WAIT_CYC   = CLK_HZ / 1000 * WAIT_MS;
  localparam int unsigned WIN_MS     = 1;
  localparam int unsigned WIN_CYC    = CLK_HZ / 1000 * WIN_MS;
  localparam int unsigned BURN_US    = 100;
  localparam int unsigned BURN_CYC   = CLK_HZ / 1_000_000 * BURN_US;
  // ==========================================================================
  // Register map and command values.
  localparam logic [7:0] A_ERR   = 8'h01;
  localparam logic [7:0] A_RST   = 8'h02;
  localparam logic [7:0] A_FUSE  = 8'h03;
  localparam logic [7:0] A_CFG_A = 8'h1c;
  localparam logic [7:0] A_CFG_B = 8'h1d;
  localparam logic [7:0] A_CFG_C = 8'h1e;
  localparam logic [7:0] A_SIG   = 8'h1f;
  localparam logic [7:0] A_RTF   = 8'hf1;
  localparam logic [7:0] V_RTF    = 8'h53;
  localparam logic [7:0] V_UNLOCK = 8'h01;
  localparam logic [7:0] V_BURN   = 8'h08;
  localparam logic [7:0] V_LOAD   = 8'h04;
  localparam logic [7:0] V_GUARDED_FUSE_RELOAD  = 8'h44;
  localparam logic [7:0] SIG_POLY = 8'h1d;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [2:0] SDA_EDGES = 3'h2;
  localparam logic [5:0] SCL_EDGES = 6'h10;
  // ==========================================================================
  // Field positions.
  localparam int B_UNLOCK = 0, B_BURN = 3, B_SRST = 0;
  localparam int B_SIGDIS = 7, B_LOWDIS = 6, B_HIGHDIS = 7;
  localparam int E_WD = 0, E_SIG = 2, E_COIL = 3, E_VOV = 4;
  localparam int E_VUV = 5, E_LOV = 6, E_LUV = 7;
  // High time of each safe-state waveform in tenths of the period.
  localparam logic [3:0] DUTY [1:11] = '{4'h0, 4'h2, 4'h0, 4'h4, 4'h0,
                                         4'h6, 4'h7, 4'h0, 4'h0, 4'h8, 4'h9};
  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {UL_IDLE, UL_DET, UL_WAIT, UL_WIN, UL_DONE} ssotp_ul_t;
  typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_AACK, I2_WR, I2_WACK,
                            I2_RD, I2_RACK} ssotp_i2_t;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] sig;
  } ssotp_cfg_t;
  typedef struct packed {
    logic [3:0] oe;
    logic       sin_p_o;
    logic       analog_en;
  } ssotp_pins_t;
  typedef struct packed {
    logic [5:0] bin;
    logic [5:0] gray;
  } ssotp_lnk_t;
  typedef struct packed {
    logic        ov_1;
    logic        ov_2;
    logic [11:1] f_1;
    logic [11:1] f_2;
    logic        sda_1;
    logic        sda_2;
    logic        sda_3;
    logic        scl_1;
    logic        scl_2;
    logic        scl_3;
    logic [5:0]  g_1;
    logic [5:0]  g_2;
    logic [5:0]  snap;
    logic [2:0]  sda_cnt;
    ssotp_ul_t   ul;
    logic [15:0] ucnt;
    logic        i2c_open;
    ssotp_i2_t   i2;
    logic [3:0]  bitc;
    logic [7:0]  sh;
    logic        rw;
    logic        first;
    logic        nak;
    logic        drv;
    logic [7:0]  ptr;
    ssotp_cfg_t  cfg;
    ssotp_cfg_t  fuse;
    logic        unlock;
    logic        burning;
    logic [15:0] bcnt;
    logic        guarded_fuse_reload;
    logic        sig_err;
    logic [15:0] pcnt;
    ssotp_pins_t pins;
  } ssotp_st_t;
endpackage : ssotp_pkg
`default_nettype wire

// ### verilog/ssotp_top.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Duty-coded waveform on positive sine output.
// - Waveform repeats at 500 Hz.
// - Listed faults give high-Z; signaling off does so only in safe state.
// - Recoverable faults release when cause clears.
// - Signature failure holds until reset.
// - Amplitude low/high checks individually disabled.
// - Power-up in operational mode, port closed.
// - Detect, wait 1 ms, 1 ms window.
// - Count 2 data and 16 clock edges.
// - Open port; transfers after supply normal.
// - Write 53h at f1h returns to function.
// - Port closed after return; unlock again.
// - Signature error latched; soft reset clears.
// - Shift-xor signature with 29 feedback.
// - Burn locked until 01h written.
// - 08h burns; busy bit self-clears.
// - 04h reloads fuses into configuration.
// - 44h does guarded plus normal reload.
module ssotp_top import ssotp_pkg::*; #(
  parameter int unsigned PWM_CYCLES  = PWM_CYC,
  parameter int unsigned WAIT_CYCLES = WAIT_CYC,
  parameter int unsigned WIN_CYCLES  = WIN_CYC,
  parameter logic [6:0]  I2C_ADDR    = 7'h40
) (
  // Clocks and reset.
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        scl_clk,
  // Supply and safety monitors.
  input  wire logic        supply_ov,
  input  wire logic [11:1] sm_fault,
  // Shared pin inputs.
  input  wire logic        sda_i,
  input  wire logic        scl_i,
  // Output pins: 0 sine+, 1 sine-, 2 cosine+, 3 cosine-.
  output logic      [3:0]  out_oe,
  output logic             sin_p_o,
  output logic             analog_en,
  // Configuration and status.
  output ssotp_cfg_t       cfg_o,
  output logic             guarded_load,
  output logic             i2c_mode
);

  // ==========================================================================
  // Helpers.
  function automatic logic [7:0] sig_calc(input logic [23:0] d);
    logic [7:0] m;
    logic [7:0] x;
    m = 8'h00;
    for (int i = 2; i >= 0; i--) begin
      x = {m[6:0], 1'b0} ^ d[i*8 +: 8];
      m = m[7] ? (x ^ SIG_POLY) : x;
    end
    return m;
  endfunction : sig_calc

  function automatic logic [5:0] gray2bin(input logic [5:0] g);
    logic [5:0] b;
    b[5] = g[5];
    for (int i = 4; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  function automatic logic [3:0] duty_of(input logic [11:1] f);
    logic [3:0] t;
    t = 4'h0;
    for (int i = 11; i >= 1; i--) begin
      if (f[i]) begin
        t = DUTY[i];
      end
    end
    return t;
  endfunction : duty_of

  function automatic logic [7:0] rd_reg(input logic [7:0] a, input ssotp_st_t st);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      A_ERR: begin
        r[E_WD]   = st.f_2[1];
        r[E_SIG]  = st.sig_err;
        r[E_COIL] = st.f_2[2];
        r[E_VOV]  = st.f_2[3];
        r[E_VUV]  = st.f_2[4];
        r[E_LOV]  = st.f_2[5];
        r[E_LUV]  = st.f_2[6];
      end
      A_FUSE: begin
        r[B_UNLOCK] = st.unlock;
        r[B_BURN]   = st.burning;
      end
      A_CFG_A: r = st.cfg.a;
      A_CFG_B: r = st.cfg.b;
      A_CFG_C: r = st.cfg.c;
      A_SIG:   r = st.cfg.sig;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rd_reg

  // ==========================================================================
  // Link clock domain: free-running edge count, handed over in gray code.
  ssotp_lnk_t l_r;
  ssotp_lnk_t l_nxt;

  always_comb begin
    l_nxt.bin  = l_r.bin + 6'h01;
    l_nxt.gray = l_nxt.bin ^ (l_nxt.bin >> 1);
  end

  always_ff @(posedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ==========================================================================
  // Main domain.
  ssotp_st_t s_r;
  ssotp_st_t s_nxt;

  logic        act;
  logic        sda;
  logic        scl;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic [11:1] f;
  logic        sigdis;
  logic        hiz;
  logic [15:0] hi;
  logic        pwm;
  logic [7:0]  rdv;

  always_comb begin
    s_nxt = s_r;
    s_nxt.guarded_fuse_reload = 1'b0;
    // Synchronisers; the first stage feeds only the second.
    s_nxt.ov_1  = supply_ov;
    s_nxt.ov_2  = s_r.ov_1;
    s_nxt.f_1   = sm_fault;
    s_nxt.f_2   = s_r.f_1;
    s_nxt.sda_1 = sda_i;
    s_nxt.sda_2 = s_r.sda_1;
    s_nxt.sda_3 = s_r.sda_2;
    s_nxt.scl_1 = scl_i;
    s_nxt.scl_2 = s_r.scl_1;
    s_nxt.scl_3 = s_r.scl_2;
    s_nxt.g_1   = l_r.gray;
    s_nxt.g_2   = s_r.g_1;

    sda   = s_r.sda_2;
    scl   = s_r.scl_2;
    rise  = scl && !s_r.scl_3;
    fall  = !scl && s_r.scl_3;
    start = scl && s_r.scl_3 && s_r.sda_3 && !sda;
    stop  = scl && s_r.scl_3 && !s_r.sda_3 && sda;
    act   = s_r.i2c_open && !s_r.ov_2;
    rdv   = rd_reg(s_r.ptr, s_r);

    // ========================================================================
    // Unlock sequence.
    case (s_r.ul)
      UL_IDLE: begin
        s_nxt.ucnt = 16'h0000;
        if (s_r.ov_2) begin
          s_nxt.ul = UL_DET;
        end
      end
      UL_DET: begin
        s_nxt.ucnt = s_r.ucnt + 16'h0001;
        if (!s_r.ov_2) begin
          s_nxt.ul = UL_IDLE;
        end else if (s_r.ucnt == 16'(OV_DET_CYC - 1)) begin
          s_nxt.ul   = UL_WAIT;
          s_nxt.ucnt = 16'h0000;
        end
      end
      UL_WAIT: begin
        s_nxt.ucnt = s_r.ucnt + 16'h0001;
        if (s_r.ucnt == 16'(WAIT_CYCLES - 1)) begin
          s_nxt.ul      = UL_WIN;
          s_nxt.ucnt    = 16'h0000;
          s_nxt.snap    = gray2bin(s_r.g_2);
          s_nxt.sda_cnt = 3'h0;
        end
      end
      UL_WIN: begin
        s_nxt.ucnt = s_r.ucnt + 16'h0001;
        if (sda && !s_r.sda_3 && s_r.sda_cnt != 3'h7) begin
          s_nxt.sda_cnt = s_r.sda_cnt + 3'h1;
        end
        if (s_r.ucnt == 16'(WIN_CYCLES - 1)) begin
          s_nxt.ul = UL_DONE;
          if (s_r.sda_cnt == SDA_EDGES &&
              gray2bin(s_r.g_2) - s_r.snap == SCL_EDGES) begin
            s_nxt.i2c_open = 1'b1;
          end
        end
      end
      UL_DONE: begin
        if (!s_r.ov_2) begin
          s_nxt.ul = UL_IDLE;
        end
      end
      default: s_nxt.ul = UL_IDLE;
    endcase

    // ========================================================================
    // Fuse burn timer. Blown fuses stay blown, so a burn only adds ones.
    if (s_r.burning) begin
      s_nxt.bcnt = s_r.bcnt + 16'h0001;
      if (s_r.bcnt == 16'(BURN_CYC - 1)) begin
        s_nxt.fuse    = s_r.fuse | s_r.cfg;
        s_nxt.burning = 1'b0;
      end
    end

    // ========================================================================
    // Serial target.
    if (!act) begin
      s_nxt.i2  = I2_IDLE;
      s_nxt.drv = 1'b0;
    end else if (start) begin
      s_nxt.i2   = I2_ADDR;
      s_nxt.bitc = 4'h0;
      s_nxt.drv  = 1'b0;
    end else if (stop) begin
      s_nxt.i2  = I2_IDLE;
      s_nxt.drv = 1'b0;
    end else begin
      case (s_r.i2)
        I2_ADDR, I2_WR: begin
          if (rise) begin
            s_nxt.sh   = {s_r.sh[6:0], sda};
            s_nxt.bitc = s_r.bitc + 4'h1;
          end else if (fall && s_r.bitc == 4'h8) begin
            if (s_r.i2 == I2_WR) begin
              s_nxt.drv   = 1'b1;
              s_nxt.i2    = I2_WACK;
              s_nxt.first = 1'b0;
              if (s_r.first) begin
                s_nxt.ptr = s_r.sh;
              end else begin
                s_nxt.ptr = s_r.ptr + 8'h01;
                case (s_r.ptr)
                  A_RST: begin
                    if (s_r.sh[B_SRST]) begin
                      s_nxt.sig_err = 1'b0;
                    end
                  end
                  A_FUSE: begin
                    case (s_r.sh)
                      V_UNLOCK: s_nxt.unlock = 1'b1;
                      V_BURN: begin
                        if (s_r.unlock && !s_r.burning) begin
                          s_nxt.burning = 1'b1;
                          s_nxt.bcnt    = 16'h0000;
                        end
                      end
                      V_LOAD: begin
                        if (!s_r.burning) begin
                          s_nxt.cfg = s_r.fuse;
                        end
                      end
                      V_GUARDED_FUSE_RELOAD: begin
                        if (!s_r.burning) begin
                          s_nxt.cfg   = s_r.fuse;
                          s_nxt.guarded_fuse_reload = 1'b1;
                        end
                      end
                      default: s_nxt.unlock = s_r.unlock;
                    endcase
                  end
                  A_CFG_A: s_nxt.cfg.a   = s_r.sh;
                  A_CFG_B: s_nxt.cfg.b   = s_r.sh;
                  A_CFG_C: s_nxt.cfg.c   = s_r.sh;
                  A_SIG:   s_nxt.cfg.sig = s_r.sh;
                  A_RTF: begin
                    if (s_r.sh == V_RTF) begin
                      s_nxt.i2c_open = 1'b0;
                      s_nxt.i2       = I2_IDLE;
                    end
                  end
                  default: s_nxt.ptr = s_r.ptr + 8'h01;
                endcase
              end
            end else if (s_r.sh[7:1] == I2C_ADDR) begin
              s_nxt.drv   = 1'b1;
              s_nxt.rw    = s_r.sh[0];
              s_nxt.first = 1'b1;
              s_nxt.i2    = I2_AACK;
            end else begin
              s_nxt.i2 = I2_IDLE;
            end
          end
        end
        I2_AACK, I2_WACK: begin
          if (fall) begin
            s_nxt.bitc = 4'h0;
            if (s_r.i2 == I2_AACK && s_r.rw) begin
              s_nxt.sh  = rdv;
              s_nxt.ptr = s_r.ptr + 8'h01;
              s_nxt.drv = ~rdv[7];
              s_nxt.i2  = I2_RD;
            end else begin
              s_nxt.drv = 1'b0;
              s_nxt.i2  = I2_WR;
            end
          end
        end
        I2_RD: begin
          if (rise) begin
            s_nxt.bitc = s_r.bitc + 4'h1;
          end else if (fall) begin
            if (s_r.bitc == 4'h8) begin
              s_nxt.drv = 1'b0;
              s_nxt.i2  = I2_RACK;
            end else begin
              s_nxt.sh  = {s_r.sh[6:0], 1'b0};
              s_nxt.drv = ~s_r.sh[6];
            end
          end
        end
        I2_RACK: begin
          if (rise) begin
            s_nxt.nak = sda;
          end else if (fall) begin
            if (s_r.nak) begin
              s_nxt.i2 = I2_IDLE;
            end else begin
              s_nxt.bitc = 4'h0;
              s_nxt.sh   = rdv;
              s_nxt.ptr  = s_r.ptr + 8'h01;
              s_nxt.drv  = ~rdv[7];
              s_nxt.i2   = I2_RD;
            end
          end
        end
        default: s_nxt.i2 = I2_IDLE;
      endcase
    end

    // ========================================================================
    // Signature check. Only functional mode sets the latch, and the set is
    // applied after the soft-reset clear so that it wins.
    if (!s_r.i2c_open && sig_calc({s_r.cfg.a, s_r.cfg.b, s_r.cfg.c}) != s_r.cfg.sig) begin
      s_nxt.sig_err = 1'b1;
    end

    // ========================================================================
    // Safe-state encoder.
    f      = s_r.f_2;
    f[7]   = s_r.sig_err;
    f[10]  = s_r.f_2[10] && !s_r.cfg.b[B_LOWDIS];
    f[11]  = s_r.f_2[11] && !s_r.cfg.a[B_HIGHDIS];
    sigdis = s_r.cfg.b[B_SIGDIS];
    hiz    = f[3] || f[5] || f[8] || f[9] || sigdis;
    hi     = 16'(32'(duty_of(f)) * (PWM_CYCLES / 10));
    pwm    = s_r.pcnt < hi;
    s_nxt.pcnt = (s_r.pcnt == 16'(PWM_CYCLES - 1)) ? 16'h0000 : s_r.pcnt + 16'h0001;

    s_nxt.pins.sin_p_o   = 1'b0;
    s_nxt.pins.analog_en = 1'b0;
    s_nxt.pins.oe        = 4'h0;
    if (s_r.i2c_open) begin
      // Open drain: only a low is ever driven on the data pin.
      s_nxt.pins.oe[0] = act && s_r.drv;
    end else if (s_r.ul == UL_WAIT || s_r.ul == UL_WIN) begin
      s_nxt.pins.oe = 4'h0;
    end else if (|f) begin
      if (!hiz) begin
        s_nxt.pins.oe[0]   = 1'b1;
        s_nxt.pins.sin_p_o = pwm;
      end
    end else begin
      s_nxt.pins.oe        = 4'hf;
      s_nxt.pins.analog_en = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r          <= '0;
      s_r.ul       <= UL_IDLE;
      s_r.i2       <= I2_IDLE;
      s_r.cfg      <= {4{CFG_RST}};
      s_r.fuse     <= {4{CFG_RST}};
      s_r.sda_1    <= 1'b1;
      s_r.sda_2    <= 1'b1;
      s_r.sda_3    <= 1'b1;
      s_r.scl_1    <= 1'b1;
      s_r.scl_2    <= 1'b1;
      s_r.scl_3    <= 1'b1;
      s_r.pins.oe  <= 4'hf;
      s_r.pins.analog_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  assign out_oe       = s_r.pins.oe;
  assign sin_p_o      = s_r.pins.sin_p_o;
  assign analog_en    = s_r.pins.analog_en;
  assign cfg_o        = s_r.cfg;
  assign guarded_load = s_r.guarded_fuse_reload;
  assign i2c_mode     = s_r.i2c_open;

endmodule : ssotp_top
`default_nettype wire

// ### bench/ssotp_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Checker on the top-level pins.
module ssotp_props import ssotp_pkg::*; #(
  parameter int unsigned WIN_CYCLES = WIN_CYC
) (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        resetn,
  // Inputs watched.
  input wire logic        supply_ov,
  input wire logic [11:1] sm_fault,
  // Outputs watched.
  input wire logic [3:0]  out_oe,
  input wire logic        sin_p_o,
  input wire logic        analog_en,
  input wire ssotp_cfg_t  cfg_o,
  input wire logic        guarded_load,
  input wire logic        i2c_mode
);
  // Cycles since the supply was last seen in overvoltage; saturates.
  logic [15:0] ov_age_r;
  logic [15:0] ov_age_nxt;
  always_comb begin
    ov_age_nxt = ov_age_r;
    if (supply_ov) begin
      ov_age_nxt = 16'h0000;
    end else if (ov_age_r != 16'hffff) begin
      ov_age_nxt = ov_age_r + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ov_age_r <= 16'hffff;
    end else begin
      ov_age_r <= ov_age_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_oper_all_drive: assert property (
    analog_en |-> out_oe == 4'hf) else $error("analog mode without all outputs");
  a_safe_others_hiz: assert property (
    !analog_en |-> out_oe[3:1] == 3'h0) else $error("safe state drives a non-sine pin");
  a_ovfault_hiz: assert property (
    (sm_fault[3] && !i2c_mode)[*4] |-> out_oe == 4'h0 && !analog_en)
    else $error("overvoltage fault not high impedance");
  a_pwm_high_min: assert property (
    $rose(sin_p_o) && !analog_en && !i2c_mode |=> (sin_p_o || !out_oe[0] || analog_en)[*8])
    else $error("safe waveform high phase too short");
  a_pwm_low_min: assert property (
    $fell(sin_p_o) && !analog_en && !i2c_mode |=> (!sin_p_o || analog_en || i2c_mode)[*8])
    else $error("safe waveform low phase too short");
  a_cfg_func_stable: assert property (
    !i2c_mode && !$past(i2c_mode) |-> $stable(cfg_o)) else $error("config moved with port closed");
  a_i2c_pins_open: assert property (
    i2c_mode |-> !analog_en && out_oe[3:1] == 3'h0 && (!out_oe[0] || !sin_p_o))
    else $error("serial mode pin use wrong");
  a_guarded_fuse_reload_one_pulse: assert property (
    guarded_load |-> i2c_mode ##1 !guarded_load) else $error("guarded reload pulse wrong");
  a_unlock_after_ov: assert property (
    $rose(i2c_mode) |-> ov_age_r <= 16'(WIN_CYCLES)) else $error("port opened without overvoltage");
  c_unlock: cover property ($rose(i2c_mode));
  c_return: cover property ($fell(i2c_mode));
  c_guarded_fuse_reload: cover property (guarded_load);
  c_pwm: cover property ($rose(sin_p_o) && !analog_en && !i2c_mode);
endmodule : ssotp_props
bind ssotp_top ssotp_props #(.WIN_CYCLES(WIN_CYCLES)) u_props (.clk(clk), .resetn(resetn),
  .supply_ov(supply_ov), .sm_fault(sm_fault), .out_oe(out_oe), .sin_p_o(sin_p_o),
  .analog_en(analog_en), .cfg_o(cfg_o), .guarded_load(guarded_load), .i2c_mode(i2c_mode));
`default_nettype wire

// ### bench/ssotp_prog.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Programming station: supply control and serial bus master.
module ssotp_prog import ssotp_pkg::*; #(
  parameter logic [6:0]  I2C_ADDR    = 7'h40,
  parameter int unsigned WAIT_CYCLES = 200,
  parameter int unsigned WIN_CYCLES  = 600
) (
  // Clock and resolved data line.
  input  wire logic clk,
  input  wire logic sda_w,
  // Open-drain pulls and supply.
  output logic      sda_lo,
  output logic      scl_lo,
  output logic      supply_ov
);
  // The pin clock only moves inside frames and unlock pulses, so it is gated from this oscillator.
  logic lclk;
  initial begin
    lclk = 1'b0;
    sda_lo = 1'b0;
    scl_lo = 1'b0;
    supply_ov = 1'b0;
    #37;
    forever #80 lclk = ~lclk;
  end
  // One phase is 640 ns, keeping pulses under 1 MHz and above the sampler's need.
  task automatic ph;
    repeat (4) @(posedge lclk);
  endtask : ph
  task automatic start;
    sda_lo = 1'b0;
    ph();
    scl_lo = 1'b0;
    ph();
    sda_lo = 1'b1;
    ph();
    scl_lo = 1'b1;
  endtask : start
  task automatic stop;
    sda_lo = 1'b1;
    ph();
    scl_lo = 1'b0;
    ph();
    sda_lo = 1'b0;
    ph();
  endtask : stop
  // Nine clocks, MSB first; a 1 in tx releases the line so rx sees the target.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_lo = !tx[i];
      ph();
      scl_lo = 1'b0;
      ph();
      rx[i] = sda_w;
      scl_lo = 1'b1;
    end
  endtask : xfer
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [8:0] r0;
    logic [8:0] r1;
    logic [8:0] r2;
    start();
    xfer({I2C_ADDR, 2'b01}, r0);
    xfer({p, 1'b1}, r1);
    xfer({d, 1'b1}, r2);
    stop();
    ok = !r0[0] && !r1[0] && !r2[0];
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [8:0] r;
    start();
    xfer({I2C_ADDR, 2'b01}, r);
    xfer({p, 1'b1}, r);
    start();
    xfer({I2C_ADDR, 2'b11}, r);
    xfer(9'h1ff, r);
    stop();
    d = r[8:1];
  endtask : rd
  task automatic unlock(input int ns, input int nc);
    supply_ov = 1'b1;
    repeat (OV_DET_CYC + WAIT_CYCLES + 40) @(negedge clk);
    for (int i = 0; i < 16; i++) begin
      scl_lo = (i < nc);
      sda_lo = (i < ns);
      ph();
      scl_lo = 1'b0;
      sda_lo = 1'b0;
      ph();
    end
    repeat (WIN_CYCLES - 430) @(negedge clk);
    supply_ov = 1'b0;
    repeat (10) @(negedge clk);
  endtask : unlock
endmodule : ssotp_prog
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Testbench.
module tb import ssotp_pkg::*;;
  localparam int unsigned PWM = 100;
  localparam int unsigned WT  = 200;
  localparam int unsigned WN  = 600;
  localparam logic [23:0] CFG = 24'h5a4083;
  logic        clk;
  logic        resetn;
  logic [11:1] sm_fault;
  logic        sda_lo;
  logic        scl_lo;
  logic        supply_ov;
  logic [3:0]  out_oe;
  logic        sin_p_o;
  logic        analog_en;
  ssotp_cfg_t  cfg_o;
  logic        guarded_load;
  logic        i2c_mode;
  logic        gl_seen;
  logic        ok;
  logic [7:0]  rb;
  logic [7:0]  sg;
  int          n_errors;
  int          samples_checked;
  // Pull-ups on both lines; the analog level is taken as high.
  wire sda_w = !(sda_lo || (out_oe[0] && !analog_en && !sin_p_o));
  wire scl_w = !scl_lo;
  ssotp_top #(.PWM_CYCLES(PWM), .WAIT_CYCLES(WT), .WIN_CYCLES(WN)) DUT (
    .clk(clk), .resetn(resetn), .scl_clk(scl_w), .supply_ov(supply_ov),
    .sm_fault(sm_fault), .sda_i(sda_w), .scl_i(scl_w), .out_oe(out_oe),
    .sin_p_o(sin_p_o), .analog_en(analog_en), .cfg_o(cfg_o),
    .guarded_load(guarded_load), .i2c_mode(i2c_mode));
  ssotp_prog #(.WAIT_CYCLES(WT), .WIN_CYCLES(WN)) P (
    .clk(clk), .sda_w(sda_w), .sda_lo(sda_lo), .scl_lo(scl_lo), .supply_ov(supply_ov));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (guarded_load === 1'b1) gl_seen <= 1'b1;
  end
  // Wide enough for the longest packed compare, so no flag bit is cut off.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] sig3(input logic [23:0] v);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 2; i >= 0; i--) m = {m[6:0], 1'b0} ^ v[i*8 +: 8] ^ (m[7] ? 8'h1d : 8'h00);
    return m;
  endfunction : sig3
  // Counts high cycles of the sine pin over one period; m of 0 sets no fault.
  task automatic duty(input int m, input int tenths);
    int hi;
    hi = 0;
    @(negedge clk);
    sm_fault = (m == 0) ? 11'h0 : 11'h1 << (m - 1);
    repeat (2 * PWM) @(negedge clk);
    repeat (PWM) begin
      @(negedge clk);
      if (sin_p_o === 1'b1 && out_oe === 4'h1) hi++;
    end
    chk(hi, tenths * PWM / 10);
    chk(out_oe, 4'h1);
    sm_fault = 11'h0;
    repeat (5) @(negedge clk);
  endtask : duty
  task automatic clr;
    for (int i = 0; i < 4; i++) P.wr(A_CFG_A + 8'(i), 8'h00, ok);
    chk(cfg_o, 32'h0);
  endtask : clr
  task automatic t_safe;
    int ms [6] = '{1, 2, 4, 6, 10, 11};
    int ts [6] = '{0, 2, 4, 6, 8, 9};
    int hz [4] = '{3, 5, 8, 9};
    foreach (ms[i]) begin
      duty(ms[i], ts[i]);
      chk(analog_en, 1'b1);
    end
    foreach (hz[i]) begin
      sm_fault = (11'h1 << (hz[i] - 1)) | 11'h1;
      repeat (5) @(negedge clk);
      chk(out_oe, 4'h0);
      sm_fault = 11'h0;
      repeat (5) @(negedge clk);
      chk(analog_en, 1'b1);
    end
    $display("test safe done");
  endtask : t_safe
  task automatic t_sig_fault;
    P.unlock(1, 16);
    chk(i2c_mode, 1'b0);
    P.unlock(2, 15);
    chk(i2c_mode, 1'b0);
    P.unlock(2, 16);
    chk(i2c_mode, 1'b1);
    for (int i = 0; i < 3; i++) P.wr(A_CFG_A + 8'(i), CFG[16-8*i +: 8], ok);
    P.wr(A_SIG, ~sg, ok);
    chk(cfg_o, {CFG, ~sg});
    P.wr(A_RTF, V_RTF, ok);
    repeat (5) @(negedge clk);
    chk(i2c_mode, 1'b0);
    duty(0, 7);
    P.unlock(2, 16);
    P.wr(A_SIG, sg, ok);
    P.wr(A_RTF, V_RTF, ok);
    duty(0, 7);
    $display("test signature done");
  endtask : t_sig_fault
  task automatic t_fuse;
    P.unlock(2, 16);
    P.wr(A_RST, 8'h01, ok);
    P.wr(A_FUSE, V_BURN, ok);
    P.rd(A_FUSE, rb);
    chk(rb, 8'h00);
    P.wr(A_FUSE, V_UNLOCK, ok);
    P.wr(A_FUSE, V_BURN, ok);
    P.rd(A_FUSE, rb);
    chk(rb, 8'h09);
    repeat (BURN_CYC + 100) @(negedge clk);
    P.rd(A_FUSE, rb);
    chk(rb, 8'h01);
    clr();
    P.wr(A_FUSE, V_LOAD, ok);
    chk(cfg_o, {CFG, sg});
    clr();
    P.wr(A_FUSE, V_GUARDED_FUSE_RELOAD, ok);
    chk(cfg_o, {CFG, sg});
    chk(gl_seen, 1'b1);
    P.wr(A_RTF, V_RTF, ok);
    repeat (10) @(negedge clk);
    chk({analog_en, i2c_mode}, 2'b10);
    $display("test fuse done");
  endtask : t_fuse
  task automatic t_after;
    @(negedge clk);
    sm_fault = 11'h200;
    repeat (5) @(negedge clk);
    chk(analog_en, 1'b1);
    sm_fault = 11'h0;
    P.wr(A_CFG_C, 8'hff, ok);
    chk({ok, cfg_o}, {1'b0, CFG, sg});
    $display("test closed port done");
  endtask : t_after
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    n_errors = 0;
    samples_checked = 0;
    gl_seen = 1'b0;
    sm_fault = 11'h0;
    resetn = 1'b0;
    sg = sig3(CFG);
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (5) @(negedge clk);
    chk({analog_en, i2c_mode, out_oe, cfg_o}, {6'h2f, 32'h0});
    t_safe();
    t_sig_fault();
    t_fuse();
    t_after();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
